// ===== src/dacdp_droop_filter.sv
module dacdp_droop_filter (
    // Clocking
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic en,
    // Stream in
    input wire logic in_valid,
    input wire logic signed [dacdp_pkg::DACDP_SW-1:0] in_data,
    // Stream out
    output logic out_valid,
    output logic signed [dacdp_pkg::DACDP_SW-1:0] out_data
);
    import dacdp_pkg::*;

    logic signed [DACDP_SW-1:0] tap_q [2];
    logic signed [DACDP_SW-1:0] tap_d [2];
    logic signed [DACDP_SW-1:0] out_q;
    logic signed [DACDP_SW-1:0] out_d;
    logic vld_q;
    logic vld_d;
    logic signed [DACDP_SW+8:0] acc;
    logic signed [DACDP_SW+8:0] shf;

    always_comb begin
        tap_d = tap_q;
        out_d = out_q;
        vld_d = in_valid;
        // Widen before multiplying so the mid tap product cannot wrap at 16 bits
        acc = (DACDP_SW+9)'(DACDP_TAP_SIDE) * (DACDP_SW+9)'(in_data)
            + (DACDP_SW+9)'(DACDP_TAP_MID) * (DACDP_SW+9)'(tap_q[0])
            + (DACDP_SW+9)'(DACDP_TAP_SIDE) * (DACDP_SW+9)'(tap_q[1]);
        shf = acc >>> DACDP_TAP_SHIFT;
        if (in_valid) begin
            tap_d[0] = in_data;
            tap_d[1] = tap_q[0];
            if (!en) begin
                out_d = in_data;
            end else if (shf > (DACDP_SW+9)'(32767)) begin
                out_d = 16'sh7FFF; // Saturate rather than wrap on overshoot
            end else if (shf < -(DACDP_SW+9)'(32768)) begin
                out_d = 16'sh8000;
            end else begin
                out_d = shf[DACDP_SW-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tap_q[0] <= '0;
            tap_q[1] <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end else if (ce) begin
            tap_q <= tap_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign out_valid = vld_q;
    assign out_data = out_q;

endmodule

// ===== src/dacdp_pkg.sv
package dacdp_pkg;

    localparam int DACDP_AW = 12;
    localparam int DACDP_DW = 8;
    localparam int DACDP_SW = 16;

    // Register offsets
    localparam logic [11:0] DACDP_CAL_PRELOAD_OFS = 12'h0ED;
    localparam logic [11:0] DACDP_FORMAT_OFS = 12'h110;
    localparam logic [11:0] DACDP_FEATURE_OFS = 12'h111;
    localparam logic [11:0] DACDP_RATIO_OFS = 12'h112;

    // Field positions
    localparam int DACDP_OFFSET_BIN_BIT = 7;
    localparam int DACDP_DROOP_BIT = 7;
    localparam int DACDP_SCALE_BIT = 5;

    // Reset values, plus the calibration preload go value
    localparam logic [7:0] DACDP_CAL_PRELOAD_RST = 8'hA6;
    localparam logic [7:0] DACDP_CAL_PRELOAD_GO = 8'hA2;
    localparam logic DACDP_OFFSET_BIN_RST = 1'h0;
    localparam logic DACDP_DROOP_RST = 1'h0;
    localparam logic DACDP_SCALE_RST = 1'h1;

    // Upsample ratio codes
    localparam logic [2:0] DACDP_RATIO_X1 = 3'h0;
    localparam logic [2:0] DACDP_RATIO_X2 = 3'h1;
    localparam logic [2:0] DACDP_RATIO_X4 = 3'h3;
    localparam logic [2:0] DACDP_RATIO_X8 = 3'h4;
    localparam logic [2:0] DACDP_RATIO_RST = DACDP_RATIO_X2;

    // Gain stage: Q2.14 fixed word, 0x4000 is unity
    localparam logic signed [15:0] DACDP_GAIN_WORD = 16'sh4000;
    localparam int DACDP_GAIN_SHIFT = 14;

    // Droop compensation taps, scaled by 16
    localparam logic signed [7:0] DACDP_TAP_SIDE = -8'sh01;
    localparam logic signed [7:0] DACDP_TAP_MID = 8'sh12;
    localparam int DACDP_TAP_SHIFT = 4;

    typedef enum logic [1:0] {
        DACDP_IDLE,
        DACDP_HOLD
    } dacdp_state_t;

endpackage

// ===== src/dacdp_top.sv
module dacdp_top (
    // Clocking
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Register port
    input wire logic [dacdp_pkg::DACDP_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dacdp_pkg::DACDP_DW-1:0] reg_wdata,
    output logic [dacdp_pkg::DACDP_DW-1:0] reg_rdata,
    // Calibration preload word
    output logic [dacdp_pkg::DACDP_DW-1:0] cal_preload,
    // Samples from link receiver
    input wire logic sample_valid,
    input wire logic [dacdp_pkg::DACDP_SW-1:0] sample_data,
    output logic sample_ready,
    // Samples to converter core
    output logic dac_valid,
    output logic [dacdp_pkg::DACDP_SW-1:0] dac_data
);
    import dacdp_pkg::*;

    // Register state
    logic [7:0] cal_q, cal_d;
    logic offset_bin_q, offset_bin_d;
    logic droop_comp_filter_on_q, droop_comp_filter_on_d;
    logic scaling_multiplier_on_q, scaling_multiplier_on_d;
    logic [2:0] upsample_ratio_select_q, upsample_ratio_select_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        cal_d = cal_q;
        offset_bin_d = offset_bin_q;
        droop_comp_filter_on_d = droop_comp_filter_on_q;
        scaling_multiplier_on_d = scaling_multiplier_on_q;
        upsample_ratio_select_d = upsample_ratio_select_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                DACDP_CAL_PRELOAD_OFS: begin
                    // Value 0xA2 is expected before a calibration run
                    cal_d = reg_wdata;
                end
                DACDP_FORMAT_OFS: begin
                    offset_bin_d = reg_wdata[DACDP_OFFSET_BIN_BIT];
                end
                DACDP_FEATURE_OFS: begin
                    droop_comp_filter_on_d = reg_wdata[DACDP_DROOP_BIT];
                    scaling_multiplier_on_d = reg_wdata[DACDP_SCALE_BIT];
                end
                DACDP_RATIO_OFS: begin
                    // Reserved codes are dropped so the ratio is always legal
                    case (reg_wdata[2:0])
                        DACDP_RATIO_X1, DACDP_RATIO_X2,
                        DACDP_RATIO_X4, DACDP_RATIO_X8: begin
                            upsample_ratio_select_d = reg_wdata[2:0];
                        end
                        default: begin
                            upsample_ratio_select_d = upsample_ratio_select_q;
                        end
                    endcase
                end
                default: begin
                    cal_d = cal_q;
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                DACDP_CAL_PRELOAD_OFS: rdata_d = cal_q;
                DACDP_FORMAT_OFS: rdata_d = {offset_bin_q, 7'h00};
                DACDP_FEATURE_OFS: begin
                    rdata_d = {droop_comp_filter_on_q, 1'b0, scaling_multiplier_on_q, 5'h00};
                end
                DACDP_RATIO_OFS: rdata_d = {5'h00, upsample_ratio_select_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cal_q <= DACDP_CAL_PRELOAD_RST;
            offset_bin_q <= DACDP_OFFSET_BIN_RST;
            droop_comp_filter_on_q <= DACDP_DROOP_RST;
            scaling_multiplier_on_q <= DACDP_SCALE_RST;
            upsample_ratio_select_q <= DACDP_RATIO_RST;
            rdata_q <= 8'h00;
        end else if (ce) begin
            cal_q <= cal_d;
            offset_bin_q <= offset_bin_d;
            droop_comp_filter_on_q <= droop_comp_filter_on_d;
            scaling_multiplier_on_q <= scaling_multiplier_on_d;
            upsample_ratio_select_q <= upsample_ratio_select_d;
            rdata_q <= rdata_d;
        end
    end

    // Upsampler: each accepted sample is repeated ratio times (zero-order hold)
    dacdp_state_t state_q, state_d;
    logic [2:0] rep_q, rep_d;
    logic [2:0] last_rep;
    logic [DACDP_SW-1:0] hold_q, hold_d;
    logic ready_q, ready_d;
    logic take;

    always_comb begin
        case (upsample_ratio_select_q)
            DACDP_RATIO_X1: last_rep = 3'h0;
            DACDP_RATIO_X2: last_rep = 3'h1;
            DACDP_RATIO_X4: last_rep = 3'h3;
            DACDP_RATIO_X8: last_rep = 3'h7;
            default: last_rep = 3'h0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        rep_d = rep_q;
        hold_d = hold_q;
        take = ready_q && sample_valid;
        case (state_q)
            DACDP_IDLE: begin
                rep_d = 3'h0;
            end
            DACDP_HOLD: begin
                rep_d = (rep_q >= last_rep) ? 3'h0 : rep_q + 3'h1;
                if (rep_q >= last_rep && !take) begin
                    state_d = DACDP_IDLE;
                end
            end
            default: begin
                state_d = DACDP_IDLE;
                rep_d = 3'h0;
            end
        endcase
        if (take) begin
            state_d = DACDP_HOLD;
            rep_d = 3'h0;
            // Offset binary becomes twos complement by inverting the sign bit
            hold_d = offset_bin_q ? {~sample_data[DACDP_SW-1], sample_data[DACDP_SW-2:0]}
                                  : sample_data;
        end
        ready_d = (state_d == DACDP_IDLE) || (rep_d >= last_rep);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= DACDP_IDLE;
            rep_q <= 3'h0;
            hold_q <= '0;
            ready_q <= 1'b1;
        end else if (ce) begin
            state_q <= state_d;
            rep_q <= rep_d;
            hold_q <= hold_d;
            ready_q <= ready_d;
        end
    end

    // Gain stage, one register deep
    logic signed [DACDP_SW-1:0] gain_q, gain_d;
    logic gain_vld_q, gain_vld_d;
    logic signed [2*DACDP_SW-1:0] prod;
    logic signed [2*DACDP_SW-1:0] prod_s;

    always_comb begin
        prod = $signed(hold_q) * DACDP_GAIN_WORD;
        prod_s = prod >>> DACDP_GAIN_SHIFT;
        gain_vld_d = (state_q == DACDP_HOLD);
        if (!scaling_multiplier_on_q) begin
            gain_d = $signed(hold_q);
        end else if (prod_s > (2*DACDP_SW)'(32767)) begin
            gain_d = 16'sh7FFF;
        end else if (prod_s < -(2*DACDP_SW)'(32768)) begin
            gain_d = 16'sh8000;
        end else begin
            gain_d = prod_s[DACDP_SW-1:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gain_q <= '0;
            gain_vld_q <= 1'b0;
        end else if (ce) begin
            gain_q <= gain_d;
            gain_vld_q <= gain_vld_d;
        end
    end

    logic signed [DACDP_SW-1:0] filt_data;

    dacdp_droop_filter u_droop (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .en(droop_comp_filter_on_q),
        .in_valid(gain_vld_q),
        .in_data(gain_q),
        .out_valid(dac_valid),
        .out_data(filt_data)
    );

    assign dac_data = filt_data;
    assign sample_ready = ready_q;
    assign reg_rdata = rdata_q;
    assign cal_preload = cal_q;

endmodule

// ===== verification/dac_datapath_config_bench.sv
module dac_datapath_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dacdp_pkg::*;
    logic clock = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, run = 0, fixed = 0;
    logic sample_valid, sample_ready, dac_valid, fmt = 0, flt = 0;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, cal_preload, d;
    logic [15:0] sample_data, dac_data, e;
    logic [15:0] x, y;
    logic gn = 1;
    longint h0 = 0, h1 = 0;
    logic [15:0] q[$];
    int bad_count = 0, checks_done = 0, odd = 0, r = 1;
    int bc[4] = '{2, 5, 6, 7};
    dacdp_top uut (.clock, .rstn, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .cal_preload, .sample_valid, .sample_data, .sample_ready, .dac_valid, .dac_data);
    dacdp_link_src src (.clock, .run, .fixed, .sample_ready, .sample_valid, .sample_data);
    function automatic logic [15:0] sat16(input longint v);
        return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : 16'(v);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clock);
        reg_rd <= 0;
        #1 check(16'(reg_rdata), 16'(x), "read");
    endtask
    task automatic stream(input logic [2:0] c, input int rr, input logic f, input logic g);
        wr(DACDP_RATIO_OFS, {5'h00, c});
        wr(DACDP_FORMAT_OFS, {f, 7'h00});
        wr(DACDP_FEATURE_OFS, {flt, 1'b0, g, 5'h00});
        r = rr;
        fmt = f;
        gn = g;
        run <= 1;
        repeat (40) @(posedge clock);
        run <= 0;
        repeat (30) @(posedge clock);
        check(16'(q.size()), 16'h0000, "drain");
    endtask
    // Reference: every taken word becomes r identical converted output words
    always @(posedge clock) begin
        if (ce && sample_valid && sample_ready) begin
            x = fmt ? {~sample_data[15], sample_data[14:0]} : sample_data;
            if (gn)
                x = sat16((longint'($signed(x)) * DACDP_GAIN_WORD) >>> DACDP_GAIN_SHIFT);
            repeat (r) q.push_back(x);
        end
        if (dac_valid) begin
            e = 'x;
            y = 'x;
            // Filter history advances on every output word, filter on or off
            if (q.size() > 0) begin
                e = q.pop_front();
                y = sat16((DACDP_TAP_SIDE * longint'($signed(e)) + DACDP_TAP_MID * h0
                    + DACDP_TAP_SIDE * h1) >>> DACDP_TAP_SHIFT);
                h1 = h0;
                h0 = longint'($signed(e));
            end
            if (flt)
                odd += int'(dac_data !== 16'h0100);
            check(dac_data, flt ? y : e, "sample");
        end
    end
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        #100000 bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h3E20));
        repeat (8) @(posedge clock);
        rstn <= 1;
        rd(DACDP_CAL_PRELOAD_OFS, 8'hA6);
        rd(DACDP_FORMAT_OFS, 8'h00);
        rd(DACDP_FEATURE_OFS, 8'h20);
        rd(DACDP_RATIO_OFS, 8'h01);
        rd(12'h113, 8'h00);
        wr(DACDP_FORMAT_OFS, 8'hFF);
        rd(DACDP_FORMAT_OFS, 8'h80);
        wr(DACDP_FEATURE_OFS, 8'hFF);
        rd(DACDP_FEATURE_OFS, 8'hA0);
        foreach (bc[i]) begin
            wr(DACDP_RATIO_OFS, {5'h1F, 3'(bc[i])});
            rd(DACDP_RATIO_OFS, 8'h01);
        end
        d = 8'($urandom);
        wr(DACDP_CAL_PRELOAD_OFS, d);
        rd(DACDP_CAL_PRELOAD_OFS, d);
        wr(DACDP_CAL_PRELOAD_OFS, DACDP_CAL_PRELOAD_GO);
        ce <= 0;
        wr(DACDP_CAL_PRELOAD_OFS, 8'h00);
        ce <= 1;
        #1 check(16'(cal_preload), 16'h00A2, "preload");
        stream(DACDP_RATIO_X1, 1, 0, 1);
        stream(DACDP_RATIO_X2, 2, 1, 0);
        stream(DACDP_RATIO_X4, 4, 0, 0);
        stream(DACDP_RATIO_X8, 8, 1, 1);
        stream(DACDP_RATIO_X1, 1, 1, 0);
        fixed <= 1;
        flt = 1;
        stream(DACDP_RATIO_X1, 1, 0, 1);
        check(16'(odd > 0), 16'h0001, "droop");
        flt = 0;
        stream(DACDP_RATIO_X1, 1, 0, 1);
        end_of_test();
    end
endmodule

// ===== verification/dacdp_chk_assertions.sv
module dacdp_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] cal_preload,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire logic dac_valid
);
    import dacdp_pkg::*;
    logic [2:0] ratio_q;
    logic [2:0] ratio_d;
    logic rd;
    logic tk;
    assign rd = ce & reg_rd;
    assign tk = ce & sample_valid & sample_ready;
    // Mirror of the ratio field; reserved codes leave it alone
    always_comb begin
        ratio_d = ratio_q;
        if (ce && reg_wr && reg_addr == DACDP_RATIO_OFS && reg_wdata[2:0] inside {0, 1, 3, 4})
            ratio_d = reg_wdata[2:0];
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            ratio_q <= DACDP_RATIO_RST;
        else
            ratio_q <= ratio_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_preload_follow: assert property (
        ce && reg_wr && reg_addr == DACDP_CAL_PRELOAD_OFS |=> cal_preload == $past(reg_wdata))
        else $error("bad preload");
    a_format_rsvd: assert property (
        rd && reg_addr == DACDP_FORMAT_OFS |=> reg_rdata[6:0] == 7'h00) else $error("bad format");
    a_feature_rsvd: assert property (
        rd && reg_addr == DACDP_FEATURE_OFS |=> !reg_rdata[6] && reg_rdata[4:0] == 5'h00)
        else $error("bad feature");
    a_ratio_mirror: assert property (
        rd && reg_addr == DACDP_RATIO_OFS |=> reg_rdata == {5'h00, $past(ratio_q)})
        else $error("bad ratio");
    a_unmapped_zero: assert property (
        rd && !(reg_addr inside {12'h0ED, 12'h110, 12'h111, 12'h112}) |=> reg_rdata == 8'h00)
        else $error("bad unmapped");
    a_reset_values: assert property (
        $rose(rstn) |-> cal_preload == DACDP_CAL_PRELOAD_RST && !dac_valid) else $error("bad reset");
    a_take_output: assert property (
        tk |-> ##[2:5] dac_valid) else $error("no output");
    a_single_ready: assert property (
        ratio_q == DACDP_RATIO_X1 && $stable(ratio_q) |-> sample_ready) else $error("not ready");
    c_x8_take: cover property (ratio_q == DACDP_RATIO_X8 && tk);
    c_unmapped: cover property (rd && reg_addr == 12'h113);
    c_ce_hold: cover property (!ce && reg_wr);
endmodule
bind dacdp_top dacdp_chk u_chk (.clock, .rstn, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .cal_preload, .sample_valid, .sample_ready, .dac_valid);

// ===== verification/dacdp_link_src.sv
module dacdp_link_src (
    input wire logic clock,
    input wire logic run,
    input wire logic fixed,
    input wire logic sample_ready,
    output logic sample_valid,
    output logic [15:0] sample_data
);
    timeunit 1ns;
    timeprecision 1ps;
    bit v;
    // A word is held until taken; idle data is inverted so nothing stale looks valid
    initial begin
        sample_valid = 0;
        sample_data = 16'h0000;
        forever begin
            @(posedge clock);
            if (!sample_valid || sample_ready) begin
                v = run && ($urandom % 4 != 0);
                sample_valid <= v;
                sample_data <= !v ? ~sample_data : fixed ? 16'h0100 : 16'($urandom);
            end
        end
    end
endmodule
